// [src/mclk_pkg.sv]
// Package: constants and types of the master clock and timing levels
package mclk_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Nominal epoch durations, rounded up to whole clocks
  localparam int unsigned EP0_NS = 120;
  localparam int unsigned EP1_NS = 15;
  localparam int unsigned EP2_NS = 75;
  localparam int unsigned EP3_NS = 15;
  localparam int unsigned EP4_NS = 15;
  typedef logic [2:0] epoch_cnt_t;
  localparam epoch_cnt_t EP0_CYC = epoch_cnt_t'((EP0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam epoch_cnt_t EP1_CYC = epoch_cnt_t'((EP1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam epoch_cnt_t EP2_CYC = epoch_cnt_t'((EP2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam epoch_cnt_t EP3_CYC = epoch_cnt_t'((EP3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam epoch_cnt_t EP4_CYC = epoch_cnt_t'((EP4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {OSC_REST, OSC_E0, OSC_E1, OSC_E2, OSC_E3, OSC_E4} osc_state_e;
  typedef struct packed {logic set; logic clear; logic advance;} strobe_s;
  typedef struct packed {logic one_three; logic two_three; logic two_four;} aux_s;

  // Strobe levels per epoch
  localparam strobe_s STB_E0 = 3'h0;
  localparam strobe_s STB_E1 = 3'h6;
  localparam strobe_s STB_E2 = 3'h7;
  localparam strobe_s STB_E3 = 3'h5;
  localparam strobe_s STB_E4 = 3'h4;

  // One-hot levels, bit 0 is level one
  localparam logic [3:0] LEVEL_INIT = 4'h4;
  localparam logic [3:0] LEVEL_FOUR = 4'h8;
  localparam aux_s AUX_INIT = 3'h7;

  // Register map
  localparam int REG_ADR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] CYCLES_OFS = 4'h8;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_DMA_EN_BIT = 2;
  localparam logic CTRL_DMA_EN_RST = 1'b0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_STB_LSB = 2;
  localparam int STAT_LEVEL_LSB = 5;
  localparam int STAT_AUX_LSB = 9;
  localparam int STAT_EPOCH_LSB = 12;
endpackage : mclk_pkg

// [src/master_oscillator.sv]
// Master oscillator: five-epoch strobe generator
`timescale 1ns/1ps
`default_nettype none
module master_oscillator
  import mclk_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  output strobe_s strobe_o,
  output osc_state_e state_o,
  output logic busy_o,
  output logic adv_rise_o,
  output logic cycle_end_o
);
  osc_state_e state_q;
  osc_state_e state_d;
  epoch_cnt_t cnt_q;
  epoch_cnt_t cnt_d;
  strobe_s strobe_q;
  logic last_tick;

  function automatic epoch_cnt_t epoch_len(input osc_state_e s);
    unique case (s)
      OSC_E0: epoch_len = EP0_CYC;
      OSC_E1: epoch_len = EP1_CYC;
      OSC_E2: epoch_len = EP2_CYC;
      OSC_E3: epoch_len = EP3_CYC;
      OSC_REST, OSC_E4: epoch_len = EP4_CYC;
    endcase
  endfunction : epoch_len

  function automatic strobe_s pattern(input osc_state_e s);
    unique case (s)
      OSC_E1: pattern = STB_E1;
      OSC_E2: pattern = STB_E2;
      OSC_E3: pattern = STB_E3;
      OSC_E4: pattern = STB_E4;
      OSC_REST, OSC_E0: pattern = STB_E0;
    endcase
  endfunction : pattern

  assign last_tick = (state_q != OSC_REST) && (cnt_q == epoch_cnt_t'(1));

  // Epoch sequencing; a stopped run still finishes the cycle
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      OSC_REST: if (run_i) state_d = OSC_E0;
      OSC_E0: if (last_tick) state_d = OSC_E1;
      OSC_E1: if (last_tick) state_d = OSC_E2;
      OSC_E2: if (last_tick) state_d = OSC_E3;
      OSC_E3: if (last_tick) state_d = OSC_E4;
      OSC_E4: if (last_tick) state_d = run_i ? OSC_E0 : OSC_REST;
    endcase
  end

  assign cnt_d = (state_d != state_q) ? epoch_len(state_d) : cnt_q - epoch_cnt_t'(1);

  // Epoch counter in base clock ticks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= OSC_REST;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d == OSC_REST) ? '0 : cnt_d;
    end
  end

  // Registered strobes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_q <= STB_E0;
    end else begin
      strobe_q <= pattern(state_d);
    end
  end

  assign strobe_o = strobe_q;
  assign state_o = state_q;
  assign busy_o = state_q != OSC_REST;
  assign adv_rise_o = (state_q == OSC_E1) && last_tick;
  assign cycle_end_o = (state_q == OSC_E4) && last_tick;
endmodule : master_oscillator
`default_nettype wire

// [src/level_generator.sv]
// Level generator: one-hot timing levels and auxiliary flags
`timescale 1ns/1ps
`default_nettype none
module level_generator
  import mclk_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic adv_i,
  input wire logic cycle_end_i,
  input wire logic repeat_level_two_i,
  input wire logic dma_hold_i,
  input wire logic dma_done_i,
  output logic [3:0] level_o,
  output aux_s aux_o
);
  logic [3:0] level_q;
  logic [3:0] level_d;
  aux_s aux_q;

  // Flag update on each advance pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aux_q <= AUX_INIT;
    end else if (adv_i) begin
      if (level_q[0]) aux_q.one_three <= 1'b1;
      if (level_q[1]) begin
        aux_q.two_three <= 1'b1;
        aux_q.two_four <= 1'b1;
      end
      if (level_q[2]) begin
        aux_q.one_three <= 1'b0;
        aux_q.two_three <= 1'b0;
      end
      if (level_q[3]) aux_q.two_four <= 1'b0;
    end
  end

  // Next level from the flags
  always_comb begin
    level_d = level_q;
    if (level_q[0] && aux_q.one_three) begin
      level_d = 4'h2;
    end else if (level_q[1] && aux_q.two_three) begin
      level_d = 4'h4;
    end else if (level_q[2] && repeat_level_two_i) begin
      level_d = 4'h2;
    end else if (level_q[2] && dma_hold_i) begin
      level_d = 4'h0;
    end else if (level_q[2] && !aux_q.two_three && aux_q.two_four) begin
      level_d = LEVEL_FOUR;
    end else if (level_q[3] && !aux_q.two_four) begin
      level_d = 4'h1;
    end
  end

  // Preset to level three; resume at level four after service
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_q <= LEVEL_INIT;
    end else if (level_q == 4'h0 && dma_done_i) begin
      level_q <= LEVEL_FOUR;
    end else if (cycle_end_i) begin
      level_q <= level_d;
    end
  end

  assign level_o = level_q;
  assign aux_o = aux_q;
endmodule : level_generator
`default_nettype wire

// [src/master_clock_timing_levels.sv]
// Top: master clock, timing levels, run flag and register slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Instructions run on a grid: levels fine, phase register coarse.
// - Oscillator gives set, clear and advance strobes over five epochs.
// - Epochs last 120, 20, 80, 20, 20 ns with levels 000,110,111,101,100.
// - After initialization run is clear and the oscillator rests silent.
// - Oscillator cycles until master clear or halt clears run.
// - A cleared run finishes the current cycle, stopping after set falls.
// - Levels step one to four, one at a time, once per cycle.
// - Initialization presets level three and all three auxiliary flags.
// - Each advance pulse updates auxiliary flags from the current level.
// - Next level is chosen from the flags when the set strobe ends.
// - Repeat-level-two turns level three back to level two.
// - Active memory access service blocks level four and clears level three.
// - When service completes, level four is set and sequencing continues.
module master_clock_timing_levels
  import mclk_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [REG_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic master_clear_button_i,
  input wire logic halt_instruction_i,
  input wire logic repeat_level_two_i,
  input wire logic dma_active_i,
  input wire logic dma_done_i,
  output strobe_s strobe_o,
  output logic [3:0] level_o,
  output logic run_flag_o
);
  logic mclr_meta_q;
  logic mclr_sync_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic [31:0] stat_w;
  logic [31:0] ctrl_w;
  logic [31:0] cycles_q;
  logic run_q;
  logic dma_en_q;
  logic req;
  logic wr_take;
  logic wr_ctrl;
  logic start_wr;
  logic clear_wr;
  logic run_clear;
  strobe_s strobe_w;
  osc_state_e osc_state;
  logic busy;
  logic adv_rise;
  logic cycle_end;
  logic dma_hold;
  logic [3:0] level_w;
  aux_s aux_w;

  // Master clear pin synchroniser
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mclr_meta_q <= 1'b0;
      mclr_sync_q <= 1'b0;
    end else begin
      mclr_meta_q <= master_clear_button_i;
      mclr_sync_q <= mclr_meta_q;
    end
  end

  // Bus request decode
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_take = req && wb_we_i && ack_q;
  assign wr_ctrl = wr_take && wb_sel_i[0] && (wb_adr_i == CTRL_OFS);
  assign start_wr = wr_ctrl && wb_dat_i[CTRL_START_BIT];
  assign clear_wr = wr_ctrl && wb_dat_i[CTRL_CLEAR_BIT];

  // Single-wait acknowledge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Read data captured in the waiting cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dat_q <= '0;
    end else if (req && !ack_q) begin
      dat_q <= rd_d;
    end
  end

  always_comb begin
    ctrl_w = '0;
    ctrl_w[CTRL_DMA_EN_BIT] = dma_en_q;
  end

  always_comb begin
    stat_w = '0;
    stat_w[STAT_RUN_BIT] = run_q;
    stat_w[STAT_BUSY_BIT] = busy;
    stat_w[STAT_STB_LSB +: 3] = strobe_w;
    stat_w[STAT_LEVEL_LSB +: 4] = level_w;
    stat_w[STAT_AUX_LSB +: 3] = aux_w;
    stat_w[STAT_EPOCH_LSB +: 3] = osc_state;
  end

  always_comb begin
    rd_d = '0;
    if (wb_adr_i == CTRL_OFS) begin
      rd_d = ctrl_w;
    end else if (wb_adr_i == STAT_OFS) begin
      rd_d = stat_w;
    end else if (wb_adr_i == CYCLES_OFS) begin
      rd_d = cycles_q;
    end
  end

  // Service enable from software
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_en_q <= CTRL_DMA_EN_RST;
    end else if (wr_ctrl) begin
      dma_en_q <= wb_dat_i[CTRL_DMA_EN_BIT];
    end
  end

  // Run flag: clears win over a start written in the same cycle
  assign run_clear = mclr_sync_q || halt_instruction_i || clear_wr;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q <= 1'b0;
    end else if (run_clear) begin
      run_q <= 1'b0;
    end else if (start_wr) begin
      run_q <= 1'b1;
    end
  end

  // Completed oscillator cycles
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cycles_q <= '0;
    end else if (cycle_end) begin
      cycles_q <= cycles_q + 32'h1;
    end
  end

  master_oscillator u_osc (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .run_i(run_q),
    .strobe_o(strobe_w),
    .state_o(osc_state),
    .busy_o(busy),
    .adv_rise_o(adv_rise),
    .cycle_end_o(cycle_end)
  );

  // Service only counts while enabled
  assign dma_hold = dma_en_q && dma_active_i;

  level_generator u_levels (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .adv_i(adv_rise),
    .cycle_end_i(cycle_end),
    .repeat_level_two_i(repeat_level_two_i),
    .dma_hold_i(dma_hold),
    .dma_done_i(dma_done_i),
    .level_o(level_w),
    .aux_o(aux_w)
  );

  // Fine grid out to the phase logic
  assign level_o = level_w;
  assign strobe_o = strobe_w;
  assign run_flag_o = run_q;
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_ep1;
    strobe_w.set && strobe_w.clear && !strobe_w.advance;
  endsequence
  sequence s_ep2;
    strobe_w.set && strobe_w.clear && strobe_w.advance;
  endsequence
  sequence s_ep3;
    strobe_w.set && !strobe_w.clear && strobe_w.advance;
  endsequence
  sequence s_ep4;
    strobe_w.set && !strobe_w.clear && !strobe_w.advance;
  endsequence
  sequence s_quiet;
    !strobe_w.set && !strobe_w.clear && !strobe_w.advance;
  endsequence

  chk_epoch_shape:
    assert property ($rose(strobe_w.set) |-> s_ep1 ##1 s_ep2 [*4] ##1 s_ep3 ##1 s_ep4 ##1 s_quiet)
    else $error("strobe epochs out of shape");

  chk_rest_epoch:
    assert property ($fell(strobe_w.set) && busy |-> s_quiet [*6] ##1 s_ep1)
    else $error("rest epoch length wrong");

  chk_quiet_idle:
    assert property (!busy |-> s_quiet)
    else $error("strobes while oscillator at rest");

  chk_start_begins:
    assert property (!busy && run_q |=> busy ##6 s_ep1)
    else $error("set run did not start a cycle");

  chk_stop_after:
    assert property (cycle_end && !run_q |=> !busy ##1 (busy == $past(run_q)))
    else $error("oscillator ran on after run cleared");

  chk_keep_cycling:
    assert property (cycle_end && run_q |=> (busy and s_quiet))
    else $error("oscillator stopped with run set");

  chk_no_truncate:
    assert property (($fell(run_q) and s_ep2) |-> ##[1:4] s_ep3 ##1 s_ep4 ##1 s_quiet)
    else $error("cycle cut short by run clear");

  chk_end_on_set:
    assert property (cycle_end |-> s_ep4 ##1 !strobe_w.set)
    else $error("cycle end not at set trailing edge");

  chk_halt_clears:
    assert property (halt_instruction_i |=> !run_q)
    else $error("halt did not clear run");

  chk_mclr_clears:
    assert property ($rose(master_clear_button_i) |-> ##[2:3] !run_q)
    else $error("master clear did not clear run");

  chk_start_sets:
    assert property (start_wr && !run_clear |=> run_q)
    else $error("start write did not set run");

  chk_init_preset:
    assert property ($rose(arst_n_i) |-> level_w == LEVEL_INIT && aux_w == AUX_INIT && !run_q)
    else $error("preset wrong after reset");

  chk_one_level:
    assert property (!dma_en_q |-> $onehot(level_w))
    else $error("not exactly one level active");

  chk_level_hold:
    assert property (!cycle_end && level_w != 4'h0 |=> $stable(level_w))
    else $error("level changed off the strobe edge");

  chk_aux_hold:
    assert property (!adv_rise |=> $stable(aux_w))
    else $error("flags changed off the advance edge");

  chk_one_to_two:
    assert property (cycle_end && level_w[0] |=> level_w == 4'h2)
    else $error("level one did not step to two");

  chk_two_to_three:
    assert property (cycle_end && level_w[1] |=> level_w == 4'h4)
    else $error("level two did not step to three");

  chk_four_to_one:
    assert property (cycle_end && level_w[3] |=> level_w == 4'h1)
    else $error("level four did not step to one");

  chk_three_to_four:
    assert property (cycle_end && level_w[2] && !repeat_level_two_i && !dma_hold |=> level_w == LEVEL_FOUR)
    else $error("level three did not step to four");

  chk_repeat_two:
    assert property (cycle_end && level_w[2] && repeat_level_two_i |=> level_w == 4'h2)
    else $error("repeat did not return to level two");

  chk_dma_block:
    assert property (cycle_end && level_w[2] && !repeat_level_two_i && dma_hold |=> level_w == 4'h0)
    else $error("service did not block level four");

  chk_dma_resume:
    assert property (level_w == 4'h0 && dma_done_i |=> level_w == LEVEL_FOUR)
    else $error("level four not set after service");

  chk_aux_level1:
    assert property (adv_rise && level_w[0] |=> aux_w.one_three)
    else $error("one-three not set in level one");

  chk_aux_level2:
    assert property (adv_rise && level_w[1] |=> aux_w.two_three && aux_w.two_four)
    else $error("flags not set in level two");

  chk_aux_level3:
    assert property (adv_rise && level_w[2] |=> !aux_w.one_three && !aux_w.two_three)
    else $error("flags not reset in level three");

  chk_aux_level4:
    assert property (adv_rise && level_w[3] |=> !aux_w.two_four)
    else $error("two-four not reset in level four");

  chk_ack_timing:
    assert property (req && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge timing wrong");

  chk_dma_enable:
    assert property (wr_ctrl |=> dma_en_q == $past(wb_dat_i[CTRL_DMA_EN_BIT]))
    else $error("service enable not written");

  chk_unmapped_read:
    assert property (req && !ack_q && !wb_we_i && wb_adr_i != CTRL_OFS && wb_adr_i != STAT_OFS
      && wb_adr_i != CYCLES_OFS |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  chk_cycle_count:
    assert property (cycle_end |=> cycles_q == $past(cycles_q) + 32'h1)
    else $error("cycle counter did not step");

  chk_adv_in_ep1:
    assert property (adv_rise |-> s_ep1 ##1 s_ep2)
    else $error("advance pulse out of place");

  chk_dma_wait:
    assert property (level_w == 4'h0 && !dma_done_i |=> level_w == 4'h0)
    else $error("level left the service stall early");

  chk_mclr_holds:
    assert property (mclr_sync_q |=> !run_q)
    else $error("run set while master clear held");
endmodule : master_clock_timing_levels
`default_nettype wire

// [tb/phase_ctrl_model.sv]
// Partner model: phase and instruction control driving the timing controls
`timescale 1ns/1ps
`default_nettype none
module phase_ctrl_model
  import mclk_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] level_i,
  input wire strobe_s strobe_i,
  input wire logic load_i,
  input wire logic [5:0] shift_load_i,
  input wire logic dma_req_i,
  input wire logic [3:0] dma_len_i,
  input wire logic halt_req_i,
  output logic repeat_level_two_o,
  output logic dma_active_o,
  output logic dma_done_o,
  output logic halt_o
);
  logic [5:0] shift_q;
  logic [3:0] svc_q;
  logic [7:0] phase_q;
  logic end_c;
  // Last cycle of epoch five closes the oscillator cycle
  assign end_c = (strobe_i == 3'h4);
  // Nonzero shift count asks for level two again
  assign repeat_level_two_o = (shift_q != 6'h0) && level_i[2];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_q <= 6'h0;
      phase_q <= 8'h0;
      halt_o <= 1'b0;
    end else begin
      halt_o <= halt_req_i;
      if (load_i) begin
        shift_q <= shift_load_i;
      end else if (end_c && level_i[2] && shift_q != 6'h0) begin
        shift_q <= shift_q - 6'h1;
      end
      if (end_c && level_i[3]) begin
        phase_q <= phase_q + 8'h1;
      end
    end
  end
  // Service request taken in level three, done after a stall
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_active_o <= 1'b0;
      dma_done_o <= 1'b0;
      svc_q <= 4'h0;
    end else begin
      dma_done_o <= 1'b0;
      if (!dma_active_o && dma_req_i && level_i[2]) begin
        dma_active_o <= 1'b1;
        svc_q <= 4'h0;
      end else if (dma_active_o && level_i == 4'h0) begin
        if (svc_q == dma_len_i) begin
          dma_active_o <= 1'b0;
          dma_done_o <= 1'b1;
        end else begin
          svc_q <= svc_q + 4'h1;
        end
      end
    end
  end
endmodule : phase_ctrl_model
`default_nettype wire

// [tb/master_clock_timing_levels_tb.sv]
// Testbench: register access, strobe timing and level sequencing
`timescale 1ns/1ps
`default_nettype none
module master_clock_timing_levels_tb
  import mclk_pkg::*;
;
  localparam logic [13:0][2:0] PAT = {3'h6, 3'h7, 3'h7, 3'h7, 3'h7, 3'h5, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic mclr = 1'b0;
  logic halt;
  logic rpt;
  logic dact;
  logic ddone;
  strobe_s strobe;
  logic [3:0] level;
  logic run;
  logic load = 1'b0;
  logic [5:0] shl = 6'h0;
  logic dreq = 1'b0;
  logic halt_req = 1'b0;
  int err_count = 0;
  int checks = 0;
  int tick = 0;
  int cyc_seen = 0;
  logic [31:0] rd;

  master_clock_timing_levels DUT (.clk_i(clk), .arst_n_i(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .master_clear_button_i(mclr), .halt_instruction_i(halt), .repeat_level_two_i(rpt), .dma_active_i(dact),
    .dma_done_i(ddone), .strobe_o(strobe), .level_o(level), .run_flag_o(run));
  phase_ctrl_model partner (.clk_i(clk), .arst_n_i(arst_n), .level_i(level), .strobe_i(strobe), .load_i(load),
    .shift_load_i(shl), .dma_req_i(dreq), .dma_len_i(4'h2), .halt_req_i(halt_req), .repeat_level_two_o(rpt),
    .dma_active_o(dact), .dma_done_o(ddone), .halt_o(halt));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    tick++;
    if (strobe === 3'h4) begin
      cyc_seen++;
    end
    if (tick == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Classic single cycle, held until ack is sampled
  task automatic wb_io(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb_io

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb_io(1'b1, a, d);
    @(negedge clk);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    wb_io(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rd_chk

  task automatic wait_stb(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (strobe !== s && n < 40);
  endtask : wait_stb

  task automatic cyc_end();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (strobe !== 3'h4 && n < 40);
    @(negedge clk);
  endtask : cyc_end

  task automatic exp_lv(input int n, input logic [31:0] seq);
    for (int i = 0; i < n; i++) begin
      cyc_end();
      check(level, seq[4*i +: 4]);
    end
  endtask : exp_lv

  task automatic quiet();
    int nz;
    nz = 0;
    repeat (20) begin
      @(negedge clk);
      if (strobe !== 3'h0) begin
        nz++;
      end
    end
    check(nz, 0);
  endtask : quiet

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check(level, LEVEL_INIT);
    check(strobe, 3'h0);
    rd_chk(STAT_OFS, 32'he80);
    rd_chk(4'hc, 32'h0);
    wr(CTRL_OFS, 32'h1);
    check(run, 1'b1);
    wait_stb(3'h6);
    for (int i = 0; i < 14; i++) begin
      check(strobe, PAT[13-i]);
      @(negedge clk);
    end
    check(level, LEVEL_FOUR);
    exp_lv(5, 32'h00018421);
    @(posedge clk);
    load <= 1'b1;
    shl <= 6'h2;
    @(posedge clk);
    load <= 1'b0;
    exp_lv(8, 32'h18424242);
    wr(CTRL_OFS, 32'h4);
    rd_chk(CTRL_OFS, 32'h4);
    @(posedge clk);
    load <= 1'b1;
    shl <= 6'h1;
    dreq <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    exp_lv(5, 32'h00004242);
    wait_stb(3'h6);
    check(level, LEVEL_FOUR);
    @(posedge clk);
    dreq <= 1'b0;
    exp_lv(1, 32'h1);
    wait_stb(3'h7);
    @(posedge clk);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(run, 1'b0);
    exp_lv(1, 32'h2);
    quiet();
    rd_chk(STAT_OFS, 32'h840);
    wr(STAT_OFS, 32'hffffffff);
    rd_chk(STAT_OFS, 32'h840);
    wr(CTRL_OFS, 32'h1);
    wait_stb(3'h7);
    @(posedge clk);
    mclr <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(run, 1'b0);
    exp_lv(1, 32'h4);
    wr(CTRL_OFS, 32'h1);
    check(run, 1'b0);
    quiet();
    @(posedge clk);
    mclr <= 1'b0;
    wr(CTRL_OFS, 32'h1);
    check(run, 1'b1);
    wr(CTRL_OFS, 32'h3);
    check(run, 1'b0);
    cyc_end();
    quiet();
    rd_chk(CYCLES_OFS, 32'h17);
    check(cyc_seen, 32'h17);
    check(partner.phase_q, 32'h4);
    report_and_stop();
  end
endmodule : master_clock_timing_levels_tb
`default_nettype wire
